// file: shared/mmc_pkg.sv
// package with register map, timing constants and types of the measurement control block
package mmc_pkg;
    // register offsets on the documented register port
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h26;
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h27;
    // field positions in the first control register
    localparam int         OUT_MODE_POS  = 7;
    localparam int         RSVD_ONE_POS  = 6;
    localparam int         OVS_LSB_POS   = 3;
    localparam int         SW_RST_POS    = 2;
    localparam int         ONE_SHOT_POS  = 1;
    localparam int         SBY_ACT_POS   = 0;
    // field positions in the second control register
    localparam int         LOAD_POS      = 5;
    localparam int         ALSEL_POS     = 4;
    localparam int         STEP_LSB_POS  = 0;
    // reset values of both control registers
    localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST  = 8'h00;
    // timebase: one millisecond tick derived from the 4 ns clock
    localparam int         CLK_PERIOD_NS = 4;
    localparam int         TICK_NS       = 1000000;
    localparam int         TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int         MS_PER_S      = 1000;
    // least spacing between samples in ms, indexed by oversample field
    localparam logic [9:0] SPACING_MS [8] = '{10'd6, 10'd10, 10'd18, 10'd34,
                                              10'd66, 10'd130, 10'd258, 10'd512};
    // length of the boot sequence in clock cycles
    localparam logic [2:0] BOOT_CYCLES   = 3'h4;

    typedef enum logic [1:0] {
        MMC_STBY,
        MMC_ACT,
        MMC_BOOT_WAIT,
        MMC_BOOT
    } mmc_state_t;

    // configuration handed to the sensing datapath
    typedef struct packed {
        logic       altimeter;
        logic [2:0] oversample;
        logic       alarm_use_captured;
    } mmc_cfg_t;
endpackage

// file: rtl/mmc_measure_ctrl.sv
// measurement mode, acquisition timing and software reboot control
// Operation
// - bit 7 selects barometer or altimeter
// - oversample ratio two to field, spacing
// - reset bit boots, reloads defaults
// - active first drops to standby, then boots
// - boot also resets the link logic
// - reset bit clears, always reads zero
// - active one-shot measures now, not self-clearing
// - standby one-shot measures once then clears
// - standby idle; active samples each step
// - target load captures next outputs once
// - selector picks programmed or captured targets
// - step field sets interval two to field seconds
// - second register bits 7:6 read zero
module mmc_measure_ctrl #(
    parameter int TICK_CYCLES = mmc_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    // register port
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    input  wire logic [7:0]       reg_wdata_i,
    output logic      [7:0]       reg_rdata_o,
    // sensing datapath
    output logic                  meas_start_o,
    input  wire logic             meas_done_i,
    output mmc_pkg::mmc_cfg_t     meas_cfg_o,
    output logic                  capture_targets_o,
    // status and link reset
    output logic                  active_o,
    output logic                  link_reset_o
);
    localparam int TW = $clog2(TICK_CYCLES);

    typedef struct packed {
        mmc_pkg::mmc_state_t state;
        logic                standby_active_bit;
        logic                one_shot_bit;
        logic                output_mode_sel;
        logic [2:0]          os;
        logic                load;
        logic                alsel;
        logic [3:0]          st;
        logic                armed;
        logic                busy;
        logic                oneshot;
        logic                trig;
        logic [TW-1:0]       tick_cnt;
        logic [25:0]         ms_cnt;
        logic [9:0]          space_cnt;
        logic [2:0]          boot_cnt;
        logic [7:0]          rdata;
        logic                start;
        logic                cap;
        logic                lrst;
    } mmc_regs_t;

    mmc_regs_t s;
    mmc_regs_t next_s;

    // all state after reset; boot reloads the same values except tick_cnt, and rdata when a read falls in the last boot cycle
    localparam mmc_regs_t RST_S = '{
        state: mmc_pkg::MMC_STBY,
        output_mode_sel:   mmc_pkg::CTRL_ONE_RST[mmc_pkg::OUT_MODE_POS],
        os:    mmc_pkg::CTRL_ONE_RST[mmc_pkg::OVS_LSB_POS +: 3],
        one_shot_bit:   mmc_pkg::CTRL_ONE_RST[mmc_pkg::ONE_SHOT_POS],
        standby_active_bit:  mmc_pkg::CTRL_ONE_RST[mmc_pkg::SBY_ACT_POS],
        load:  mmc_pkg::CTRL_TWO_RST[mmc_pkg::LOAD_POS],
        alsel: mmc_pkg::CTRL_TWO_RST[mmc_pkg::ALSEL_POS],
        st:    mmc_pkg::CTRL_TWO_RST[mmc_pkg::STEP_LSB_POS +: 4],
        default: '0
    };

    logic wr_one;
    logic wr_two;
    logic tick;
    logic interval_hit;

    // address decode of the two control registers
    always_comb begin
        wr_one = 1'b0;
        wr_two = 1'b0;
        if (reg_addr_i == mmc_pkg::CTRL_ONE_ADDR) begin
            wr_one = reg_wr_i;
        end else if (reg_addr_i == mmc_pkg::CTRL_TWO_ADDR) begin
            wr_two = reg_wr_i;
        end
    end

    assign tick         = (s.tick_cnt == TW'(TICK_CYCLES - 1));
    // interval of 2^step seconds counted in ms ticks
    assign interval_hit = tick && (s.ms_cnt >= (26'(mmc_pkg::MS_PER_S) << s.st) - 26'h1);

    // next state of the whole block
    always_comb begin
        next_s       = s;
        next_s.start = 1'b0;
        next_s.cap   = 1'b0;
        next_s.lrst  = 1'b0;
        next_s.tick_cnt = tick ? '0 : s.tick_cnt + TW'(1);
        if (tick && s.space_cnt != 10'h0) begin
            next_s.space_cnt = s.space_cnt - 10'h1;
        end
        // end of a conversion: capture targets, finish a one-shot
        if (meas_done_i && s.busy) begin
            next_s.busy = 1'b0;
            if (s.armed) begin
                next_s.cap   = 1'b1;
                next_s.armed = 1'b0;
            end
            if (s.oneshot) begin
                next_s.one_shot_bit     = 1'b0;
                next_s.oneshot = 1'b0;
            end
        end
        // host writes; a write of one-shot after the clear above still wins
        if (s.state == mmc_pkg::MMC_STBY || s.state == mmc_pkg::MMC_ACT) begin
            if (wr_one) begin
                next_s.output_mode_sel  = reg_wdata_i[mmc_pkg::OUT_MODE_POS];
                next_s.os   = reg_wdata_i[mmc_pkg::OVS_LSB_POS +: 3];
                next_s.one_shot_bit  = reg_wdata_i[mmc_pkg::ONE_SHOT_POS];
                next_s.standby_active_bit = reg_wdata_i[mmc_pkg::SBY_ACT_POS];
                // only a rising one-shot bit triggers, so host must clear first
                if (reg_wdata_i[mmc_pkg::ONE_SHOT_POS] && !s.one_shot_bit) begin
                    next_s.trig    = 1'b1;
                    next_s.oneshot = !reg_wdata_i[mmc_pkg::SBY_ACT_POS];
                end
            end
            if (wr_two) begin
                if (reg_wdata_i[mmc_pkg::LOAD_POS] && !s.load) begin
                    next_s.armed = 1'b1;
                end
                next_s.load  = reg_wdata_i[mmc_pkg::LOAD_POS];
                next_s.alsel = reg_wdata_i[mmc_pkg::ALSEL_POS];
                next_s.st    = reg_wdata_i[mmc_pkg::STEP_LSB_POS +: 4];
            end
        end
        case (s.state)
            mmc_pkg::MMC_STBY: begin
                next_s.ms_cnt = '0;
                if (wr_one && reg_wdata_i[mmc_pkg::SW_RST_POS]) begin
                    next_s.state = mmc_pkg::MMC_BOOT_WAIT;
                    next_s.standby_active_bit  = 1'b0;
                    next_s.trig  = 1'b0;
                end else if (next_s.standby_active_bit) begin
                    next_s.state = mmc_pkg::MMC_ACT;
                end
            end
            mmc_pkg::MMC_ACT: begin
                next_s.ms_cnt = tick ? s.ms_cnt + 26'h1 : s.ms_cnt;
                if (interval_hit) begin
                    next_s.ms_cnt = '0;
                    next_s.trig   = 1'b1;
                end
                if (wr_one && reg_wdata_i[mmc_pkg::SW_RST_POS]) begin
                    // drop to standby first; reboot once conversion ends
                    next_s.state = mmc_pkg::MMC_BOOT_WAIT;
                    next_s.standby_active_bit  = 1'b0;
                    next_s.trig  = 1'b0;
                end else if (!next_s.standby_active_bit) begin
                    next_s.state = mmc_pkg::MMC_STBY;
                end
            end
            mmc_pkg::MMC_BOOT_WAIT: begin
                if (!s.busy) begin
                    next_s.state    = mmc_pkg::MMC_BOOT;
                    next_s.boot_cnt = mmc_pkg::BOOT_CYCLES - 3'h1;
                    next_s.lrst     = 1'b1;
                end
            end
            mmc_pkg::MMC_BOOT: begin
                next_s.lrst     = 1'b1;
                next_s.boot_cnt = s.boot_cnt - 3'h1;
                if (s.boot_cnt == 3'h0) begin
                    // reload defaults; reset bit is never stored
                    next_s          = RST_S;
                    next_s.tick_cnt = s.tick_cnt;
                end
            end
            default: next_s.state = mmc_pkg::MMC_STBY;
        endcase
        // start a conversion once the least spacing has run out
        if (next_s.trig && !next_s.busy && s.space_cnt == 10'h0
            && (s.state == mmc_pkg::MMC_STBY || s.state == mmc_pkg::MMC_ACT)
            && next_s.state == s.state) begin
            next_s.trig      = 1'b0;
            next_s.busy      = 1'b1;
            next_s.start     = 1'b1;
            next_s.space_cnt = mmc_pkg::SPACING_MS[s.os];
        end
        // read data; reserved and reset bits read zero
        if (reg_rd_i && reg_addr_i == mmc_pkg::CTRL_ONE_ADDR) begin
            next_s.rdata = {s.output_mode_sel, 1'b0, s.os, 1'b0, s.one_shot_bit, s.standby_active_bit};
        end else if (reg_rd_i && reg_addr_i == mmc_pkg::CTRL_TWO_ADDR) begin
            next_s.rdata = {2'b00, s.load, s.alsel, s.st};
        end else if (reg_rd_i) begin
            next_s.rdata = 8'h00;
        end
    end

    // state register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            s <= RST_S;
        end else begin
            s <= next_s;
        end
    end

    // outputs come from flip-flops, except active_o, which ORs busy with the active state
    assign reg_rdata_o                   = s.rdata;
    assign meas_start_o                  = s.start;
    assign capture_targets_o             = s.cap;
    assign link_reset_o                  = s.lrst;
    assign active_o                      = s.busy || s.state == mmc_pkg::MMC_ACT;
    assign meas_cfg_o.altimeter          = s.output_mode_sel;
    assign meas_cfg_o.oversample         = s.os;
    assign meas_cfg_o.alarm_use_captured = s.alsel;

    // checks beside the logic
    sequence boot_enter_s;
        s.state == mmc_pkg::MMC_BOOT_WAIT && !s.busy;
    endsequence
    sequence boot_run_s;
        link_reset_o [*4] ##1 !link_reset_o;
    endsequence

    boot_link_reset_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        boot_enter_s |=> boot_run_s)
        else $error("link reset not held for the boot length");
    rst_bit_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        reg_rd_i && reg_addr_i == mmc_pkg::CTRL_ONE_ADDR |=> !reg_rdata_o[2] && !reg_rdata_o[6])
        else $error("reset or reserved bit read as one");
    ctrl_two_rsvd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        reg_rd_i && reg_addr_i == mmc_pkg::CTRL_TWO_ADDR |=> reg_rdata_o[7:6] == 2'b00)
        else $error("reserved bits of second register read nonzero");
    alt_mode_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_one && s.state == mmc_pkg::MMC_STBY |=> meas_cfg_o.altimeter == $past(reg_wdata_i[7]))
        else $error("output mode not taken from write");
    active_reboot_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s.state == mmc_pkg::MMC_ACT && wr_one && reg_wdata_i[2]
        |=> s.state == mmc_pkg::MMC_BOOT_WAIT && !s.standby_active_bit)
        else $error("reboot from active did not pass through standby");
    oneshot_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s.oneshot && s.busy && meas_done_i && !wr_one |=> !s.one_shot_bit && !active_o)
        else $error("standby one-shot did not clear");
    capture_once_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        capture_targets_o |-> $past(s.armed && s.busy && meas_done_i) && !s.armed)
        else $error("capture without armed target load");
    spacing_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        meas_start_o |-> s.busy && s.space_cnt == mmc_pkg::SPACING_MS[$past(s.os)])
        else $error("sample spacing not loaded on start");
    standby_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        meas_start_o |-> s.standby_active_bit || s.oneshot)
        else $error("conversion started in standby without one-shot");

    // standby one-shot: conversion starts on the next edge while the part stays in standby
    sequence standby_shot_s;
        s.state == mmc_pkg::MMC_STBY && wr_one && !s.one_shot_bit && !s.busy && s.space_cnt == 10'h0
        && reg_wdata_i[2:0] == 3'h2;
    endsequence
    standby_shot_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        standby_shot_s |=> meas_start_o && s.one_shot_bit && s.oneshot && active_o)
        else $error("standby one-shot did not start a conversion");

    // active one-shot: immediate start, and the bit is left set for the host to clear
    sequence active_shot_s;
        s.state == mmc_pkg::MMC_ACT && wr_one && !s.one_shot_bit && !s.busy && s.space_cnt == 10'h0
        && reg_wdata_i[2:0] == 3'h3;
    endsequence
    active_shot_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        active_shot_s |=> meas_start_o && s.one_shot_bit && !s.oneshot)
        else $error("active one-shot did not start at once");

    // end of an interval starts a conversion and restarts the millisecond count
    periodic_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        s.state == mmc_pkg::MMC_ACT && interval_hit && !wr_one && !s.busy
        && s.space_cnt == 10'h0 |=> meas_start_o && s.ms_cnt == 26'h0)
        else $error("interval end did not start a conversion");

    // last boot cycle brings back every default, standby and a quiet link
    sequence boot_last_s;
        s.state == mmc_pkg::MMC_BOOT && s.boot_cnt == 3'h0;
    endsequence
    boot_reload_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        boot_last_s |=> s.state == mmc_pkg::MMC_STBY && {s.output_mode_sel, s.os, s.one_shot_bit, s.standby_active_bit} == 6'h00
        && {s.load, s.alsel, s.st} == 6'h00 && !s.armed && !link_reset_o)
        else $error("boot did not restore the defaults");

    // the link is only held in reset while the boot runs
    link_reset_boot_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        link_reset_o |-> s.state == mmc_pkg::MMC_BOOT)
        else $error("link reset outside the boot");

    // host writes that arrive during a pending or running boot must not land
    boot_write_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (s.state == mmc_pkg::MMC_BOOT_WAIT || (s.state == mmc_pkg::MMC_BOOT && s.boot_cnt != 3'h0))
        && (wr_one || wr_two) |=> $stable(meas_cfg_o))
        else $error("write landed during boot");
endmodule

// file: verification/mmc_sense_model.sv
// behavioural sensing datapath that answers the latest conversion start with a done pulse
module mmc_sense_model #(
    parameter int CONV_CYCLES = 8
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // conversion handshake
    input  wire logic meas_start_i,
    output logic      meas_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int conv_left;

    // one conversion in flight; a start while busy restarts the count, as a real front end would
    always @(posedge sys_clk_i) begin
        meas_done_o <= 1'b0;
        if (!rst_b_i) begin
            conv_left <= 0;
        end else if (meas_start_i) begin
            conv_left <= CONV_CYCLES;
        end else if (conv_left == 1) begin
            meas_done_o <= 1'b1; // pressure plus temperature result ready
            conv_left   <= 0;
        end else if (conv_left > 1) begin
            conv_left <= conv_left - 1;
        end
    end
endmodule

// file: verification/mmc_measure_ctrl_test.sv
// register-level tests of the measurement mode control block
module mmc_measure_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICKS = 10; // short millisecond so second-long steps stay cheap
    logic              sys_clk_i = 1'b0;
    logic              rst_b_i = 1'b0;
    logic [7:0]        reg_addr_i = 8'h00;
    logic              reg_wr_i = 1'b0;
    logic              reg_rd_i = 1'b0;
    logic [7:0]        reg_wdata_i = 8'h00;
    logic [7:0]        reg_rdata_o;
    logic              meas_start_o;
    logic              meas_done_i;
    mmc_pkg::mmc_cfg_t meas_cfg_o;
    logic              capture_targets_o;
    logic              active_o;
    logic              link_reset_o;
    int                num_errors = 0;
    int                check_count = 0;
    int                starts = 0;
    int                caps = 0;
    int                link_cyc = 0;
    int                n0;
    logic [7:0]        rv;

    mmc_measure_ctrl #(.TICK_CYCLES(TICKS)) mmc_measure_ctrl_i (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .meas_start_o(meas_start_o), .meas_done_i(meas_done_i),
        .meas_cfg_o(meas_cfg_o), .capture_targets_o(capture_targets_o),
        .active_o(active_o), .link_reset_o(link_reset_o));
    mmc_sense_model mmc_sense_model_i (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .meas_start_i(meas_start_o), .meas_done_o(meas_done_i));

    // 250 MHz clock
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // count start and capture pulses and link reset cycles so tests can compare totals instead of chasing edges
    always @(posedge sys_clk_i) begin
        if (meas_start_o === 1'b1) starts++;
        if (capture_targets_o === 1'b1) caps++;
        if (link_reset_o === 1'b1) link_cyc++;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // read data is settled one cycle after the edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        @(posedge sys_clk_i);
        #1 d = reg_rdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("register %h", a), d, exp);
    endtask

    // bounded wait for the next conversion start
    task automatic wait_start(input int limit);
        int base;
        base = starts;
        for (int i = 0; i < limit && starts == base; i++) @(posedge sys_clk_i);
        chk("conversion started", 8'(starts - base), 8'h01);
    endtask

    task automatic boot_chk();
        int base;
        base = link_cyc;
        repeat (200) @(posedge sys_clk_i);
        chk("link reset cycles", 8'(link_cyc - base), 8'h04);
        rd_chk(mmc_pkg::CTRL_ONE_ADDR, 8'h00);
        rd_chk(mmc_pkg::CTRL_TWO_ADDR, 8'h00);
        chk("active", {7'h00, active_o}, 8'h00);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog sized well past the longest periodic step used below
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rd_chk(mmc_pkg::CTRL_ONE_ADDR, 8'h00);
        rd_chk(mmc_pkg::CTRL_TWO_ADDR, 8'h00);
        rd_chk(8'h28, 8'h00);
        // reserved bits and all configuration fields, written while in standby
        wr(mmc_pkg::CTRL_TWO_ADDR, 8'hff);
        rd_chk(mmc_pkg::CTRL_TWO_ADDR, 8'h3f);
        wr(mmc_pkg::CTRL_ONE_ADDR, 8'hf8);
        rd_chk(mmc_pkg::CTRL_ONE_ADDR, 8'hb8);
        chk("config", {3'h0, meas_cfg_o}, 8'h1f);
        // reboot from standby restores every default
        wr(mmc_pkg::CTRL_ONE_ADDR, 8'h04);
        boot_chk();
        chk("config", {3'h0, meas_cfg_o}, 8'h00);
        // one-shot in standby with a target load armed
        n0 = caps;
        wr(mmc_pkg::CTRL_TWO_ADDR, 8'h30);
        wr(mmc_pkg::CTRL_ONE_ADDR, 8'h02);
        wait_start(20);
        chk("active", {7'h00, active_o}, 8'h01);
        repeat (20) @(posedge sys_clk_i);
        chk("captures", 8'(caps - n0), 8'h01);
        rd_chk(mmc_pkg::CTRL_ONE_ADDR, 8'h00);
        chk("active", {7'h00, active_o}, 8'h00);
        // second one-shot must wait out the 6 ms spacing and must not capture again
        wr(mmc_pkg::CTRL_ONE_ADDR, 8'h02);
        wait_start(100);
        repeat (20) @(posedge sys_clk_i);
        chk("captures", 8'(caps - n0), 8'h01);
        // periodic mode, step field 0: first sample after one second
        wr(mmc_pkg::CTRL_ONE_ADDR, 8'h01);
        n0 = starts;
        repeat (9900) @(posedge sys_clk_i);
        chk("early samples", 8'(starts - n0), 8'h00);
        wait_start(400);
        chk("active", {7'h00, active_o}, 8'h01);
        // one-shot while active measures at once and stays set
        repeat (100) @(posedge sys_clk_i);
        wr(mmc_pkg::CTRL_ONE_ADDR, 8'h03);
        wait_start(100);
        repeat (20) @(posedge sys_clk_i);
        rd_chk(mmc_pkg::CTRL_ONE_ADDR, 8'h03);
        // reboot from active drops to standby first
        wr(mmc_pkg::CTRL_ONE_ADDR, 8'h07);
        boot_chk();
        tally_and_finish();
    end
endmodule
